// *** common/rfid_pkg.sv ***
`default_nettype none
package rfid_pkg;
   localparam int unsigned SYS_CLK_HZ = 200_000_000;
   localparam int unsigned CARRIER_HZ = 125_000;
   localparam int unsigned SAMPLE_CARRIER_PERIODS = 32;
   localparam int unsigned SAMPLE_CYCLES =
      SYS_CLK_HZ / CARRIER_HZ * SAMPLE_CARRIER_PERIODS;
   localparam int unsigned HALF_BITS = 128;
   localparam int unsigned FRAME_BITS = 64;
   localparam int unsigned ID_BITS = 40;
   localparam int unsigned HEADER_BITS = 9;
   localparam int unsigned ROWS = 10;
   localparam int unsigned ROW_DATA = 4;
   localparam int unsigned ROW_BITS = 5;
   localparam int unsigned COL_PARITY_POS = 59;
   localparam int unsigned SHIFT_EDGES = 39;
   localparam int unsigned RESTART_NS = 100;
   localparam int unsigned RESTART_CYCLES =
      (RESTART_NS * (SYS_CLK_HZ / 1_000_000) + 999) / 1000;
   localparam int unsigned SCK_MIN_NS = 100;
   localparam int unsigned SCK_CYCLES =
      (SCK_MIN_NS * (SYS_CLK_HZ / 1_000_000) + 999) / 1000;
   localparam int unsigned FIFO_DEPTH = 2;

   typedef enum logic [1:0] {
      acquire_phase,
      format_check_phase,
      transfer_phase
   } seq_state_t;

   typedef enum logic [2:0] {
      host_off,
      host_restart,
      host_wait_found,
      host_sample,
      host_sck_high,
      host_sck_low,
      host_push
   } host_state_t;
endpackage : rfid_pkg
`default_nettype wire

// *** common/rfid_link_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface rfid_link_if;
   logic power_on;
   logic restart;
   logic shift_clk;
   logic found;
   logic serial_id_out;

   modport dev (
      input power_on,
      input restart,
      input shift_clk,
      output found,
      output serial_id_out
   );

   modport host (
      output power_on,
      output restart,
      output shift_clk,
      input found,
      input serial_id_out
   );
endinterface : rfid_link_if
`default_nettype wire

// *** hw/rfid_tag_frame_decoder.sv ***
`timescale 1ns/1ps
`default_nettype none
module rfid_tag_frame_decoder #(
   parameter int unsigned SAMPLE_CYCLES = rfid_pkg::SAMPLE_CYCLES
) (
   input wire logic sys_clk_i,
   input wire logic rstn_i,
   input wire logic tag_half_bit_i,
   rfid_link_if.dev link
);
   localparam int unsigned CW = $clog2(SAMPLE_CYCLES + 1);
   localparam int unsigned FW = $clog2(rfid_pkg::HALF_BITS + 1);
   localparam int unsigned RW = $clog2(rfid_pkg::FRAME_BITS);
   localparam int unsigned SW = $clog2(rfid_pkg::SHIFT_EDGES + 1);

   function automatic logic manchester_ok(
      input logic [rfid_pkg::HALF_BITS-1:0] h
   );
      logic ok;
      ok = 1'b1;
      for (int j = 0; j < rfid_pkg::FRAME_BITS; j++) begin
         ok = ok & (h[2*j] ^ h[2*j+1]);
      end
      return ok;
   endfunction : manchester_ok

   // frame bit i (0 = oldest) sits at f[63-i]
   function automatic logic frame_ok(
      input logic [rfid_pkg::FRAME_BITS-1:0] f
   );
      logic ok;
      logic col;
      int top;
      ok = 1'b1;
      top = rfid_pkg::FRAME_BITS - 1;
      for (int i = 0; i < rfid_pkg::HEADER_BITS; i++) begin
         ok = ok & f[top-i];
      end
      for (int r = 0; r < rfid_pkg::ROWS; r++) begin
         col = 1'b0;
         for (int c = 0; c < rfid_pkg::ROW_BITS; c++) begin
            col = col ^ f[top-rfid_pkg::HEADER_BITS-rfid_pkg::ROW_BITS*r-c];
         end
         ok = ok & ~col;
      end
      for (int c = 0; c < rfid_pkg::ROW_DATA; c++) begin
         col = f[top-rfid_pkg::COL_PARITY_POS-c];
         for (int r = 0; r < rfid_pkg::ROWS; r++) begin
            col = col ^ f[top-rfid_pkg::HEADER_BITS-rfid_pkg::ROW_BITS*r-c];
         end
         ok = ok & ~col;
      end
      ok = ok & ~f[0];
      return ok;
   endfunction : frame_ok

   function automatic logic [rfid_pkg::ID_BITS-1:0] extract_id(
      input logic [rfid_pkg::FRAME_BITS-1:0] f
   );
      logic [rfid_pkg::ID_BITS-1:0] id;
      int top;
      id = '0;
      top = rfid_pkg::FRAME_BITS - 1;
      for (int r = 0; r < rfid_pkg::ROWS; r++) begin
         for (int c = 0; c < rfid_pkg::ROW_DATA; c++) begin
            id[rfid_pkg::ID_BITS-1-rfid_pkg::ROW_DATA*r-c] =
               f[top-rfid_pkg::HEADER_BITS-rfid_pkg::ROW_BITS*r-c];
         end
      end
      return id;
   endfunction : extract_id

   rfid_pkg::seq_state_t state_q;
   logic [2:0] sck_sync_q;
   logic [1:0] restart_sync_q;
   logic [1:0] power_sync_q;
   logic [1:0] tag_sync_q;
   logic [CW-1:0] sample_cnt_q;
   logic sample_tick;
   logic [rfid_pkg::HALF_BITS-1:0] half_q;
   logic [FW-1:0] fill_q;
   logic [rfid_pkg::FRAME_BITS-1:0] frame_q;
   logic [rfid_pkg::FRAME_BITS-1:0] frame_d;
   logic [RW-1:0] rot_q;
   logic [rfid_pkg::ID_BITS-1:0] id_q;
   logic [SW-1:0] shift_cnt_q;
   logic restart_s;
   logic power_s;
   logic sck_rise;
   logic hold_idle;
   logic acq_ready;
   logic check_pass;
   logic check_fail;

   // first stages feed only the second stages
   always_ff @(posedge sys_clk_i) begin
      if (!rstn_i) begin
         sck_sync_q <= 3'h0;
         restart_sync_q <= 2'h0;
         power_sync_q <= 2'h0;
         tag_sync_q <= 2'h0;
      end else begin
         sck_sync_q <= {sck_sync_q[1:0], link.shift_clk};
         restart_sync_q <= {restart_sync_q[0], link.restart};
         power_sync_q <= {power_sync_q[0], link.power_on};
         tag_sync_q <= {tag_sync_q[0], tag_half_bit_i};
      end
   end

   assign restart_s = restart_sync_q[1];
   assign power_s = power_sync_q[1];
   assign sck_rise = sck_sync_q[1] & ~sck_sync_q[2];
   assign hold_idle = !power_s || restart_s;
   assign acq_ready = (fill_q == FW'(rfid_pkg::HALF_BITS))
                      && manchester_ok(half_q);
   assign check_pass = (state_q == rfid_pkg::format_check_phase)
                       && frame_ok(frame_q);
   assign check_fail = (state_q == rfid_pkg::format_check_phase)
                       && !frame_ok(frame_q)
                       && (rot_q == RW'(rfid_pkg::FRAME_BITS - 1));

   // sequencer
   always_ff @(posedge sys_clk_i) begin
      if (!rstn_i || hold_idle) begin
         state_q <= rfid_pkg::acquire_phase;
      end else begin
         unique case (state_q)
            rfid_pkg::acquire_phase: begin
               if (acq_ready) begin
                  state_q <= rfid_pkg::format_check_phase;
               end
            end
            rfid_pkg::format_check_phase: begin
               if (check_pass) begin
                  state_q <= rfid_pkg::transfer_phase;
               end else if (check_fail) begin
                  state_q <= rfid_pkg::acquire_phase;
               end
            end
            rfid_pkg::transfer_phase: begin
               state_q <= rfid_pkg::transfer_phase;
            end
         endcase
      end
   end

   // carrier/32 sample enable, runs only while acquiring
   always_ff @(posedge sys_clk_i) begin
      if (!rstn_i || hold_idle || state_q != rfid_pkg::acquire_phase) begin
         sample_cnt_q <= '0;
      end else if (sample_cnt_q == CW'(SAMPLE_CYCLES - 1)) begin
         sample_cnt_q <= '0;
      end else begin
         sample_cnt_q <= sample_cnt_q + 1'b1;
      end
   end

   assign sample_tick = (state_q == rfid_pkg::acquire_phase)
                        && (sample_cnt_q == CW'(SAMPLE_CYCLES - 1));

   // sliding window: a misaligned half-bit pairing fails and slides on
   always_ff @(posedge sys_clk_i) begin
      if (!rstn_i || hold_idle || check_fail) begin
         half_q <= '0;
         fill_q <= '0;
      end else if (sample_tick) begin
         half_q <= {half_q[rfid_pkg::HALF_BITS-2:0], tag_sync_q[1]};
         if (fill_q != FW'(rfid_pkg::HALF_BITS)) begin
            fill_q <= fill_q + 1'b1;
         end
      end
   end

   // earlier half of each pair gives the bit value
   always_comb begin
      frame_d = '0;
      for (int j = 0; j < rfid_pkg::FRAME_BITS; j++) begin
         frame_d[j] = half_q[2*j+1];
      end
   end

   // one rotation per cycle finds the header at any alignment
   always_ff @(posedge sys_clk_i) begin
      if (!rstn_i || hold_idle) begin
         frame_q <= '0;
         rot_q <= '0;
      end else if (state_q == rfid_pkg::acquire_phase) begin
         frame_q <= frame_d;
         rot_q <= '0;
      end else if (state_q == rfid_pkg::format_check_phase
                   && !check_pass) begin
         frame_q <= {frame_q[rfid_pkg::FRAME_BITS-2:0],
                     frame_q[rfid_pkg::FRAME_BITS-1]};
         rot_q <= rot_q + 1'b1;
      end
   end

   // id loads on the same edge that raises found
   always_ff @(posedge sys_clk_i) begin
      if (!rstn_i || hold_idle) begin
         id_q <= '0;
         shift_cnt_q <= '0;
      end else if (check_pass) begin
         id_q <= extract_id(frame_q);
         shift_cnt_q <= '0;
      end else if (state_q == rfid_pkg::transfer_phase && sck_rise
                   && shift_cnt_q != SW'(rfid_pkg::SHIFT_EDGES)) begin
         id_q <= {id_q[rfid_pkg::ID_BITS-2:0], 1'b0};
         shift_cnt_q <= shift_cnt_q + 1'b1;
      end
   end

   assign link.found = (state_q == rfid_pkg::transfer_phase);
   assign link.serial_id_out = id_q[rfid_pkg::ID_BITS-1];
endmodule : rfid_tag_frame_decoder
`default_nettype wire

// *** hw/rfid_host_reader.sv ***
`timescale 1ns/1ps
`default_nettype none
module rfid_host_reader #(
   parameter int unsigned WIDTH = rfid_pkg::ID_BITS,
   parameter int unsigned DEPTH = rfid_pkg::FIFO_DEPTH
) (
   input wire logic sys_clk_i,
   input wire logic rstn_i,
   input wire logic power_en_i,
   output logic [WIDTH-1:0] id_data_o,
   output logic id_valid_o,
   input wire logic id_ready_i,
   rfid_link_if.host link
);
   localparam int unsigned TW = $clog2(rfid_pkg::SCK_CYCLES
                                       + rfid_pkg::RESTART_CYCLES + 1);
   localparam int unsigned BW = $clog2(WIDTH + 1);
   localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int unsigned NW = $clog2(DEPTH + 1);

   rfid_pkg::host_state_t state_q;
   logic [1:0] found_sync_q;
   logic [1:0] serial_sync_q;
   logic [TW-1:0] timer_q;
   logic [BW-1:0] bits_q;
   logic [WIDTH-1:0] word_q;
   logic power_q;
   logic restart_q;
   logic sck_q;
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [PW-1:0] wr_ptr_q;
   logic [PW-1:0] rd_ptr_q;
   logic [NW-1:0] count_q;
   logic in_ready;
   logic push;
   logic pop;

   always_ff @(posedge sys_clk_i) begin
      if (!rstn_i) begin
         found_sync_q <= 2'h0;
         serial_sync_q <= 2'h0;
      end else begin
         found_sync_q <= {found_sync_q[0], link.found};
         serial_sync_q <= {serial_sync_q[0], link.serial_id_out};
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (!rstn_i || !power_en_i) begin
         state_q <= rfid_pkg::host_off;
         power_q <= 1'b0;
         restart_q <= 1'b0;
         sck_q <= 1'b0;
         timer_q <= '0;
         bits_q <= '0;
         word_q <= '0;
      end else begin
         unique case (state_q)
            rfid_pkg::host_off: begin
               power_q <= 1'b1;
               restart_q <= 1'b1;
               timer_q <= TW'(rfid_pkg::RESTART_CYCLES - 1);
               state_q <= rfid_pkg::host_restart;
            end
            rfid_pkg::host_restart: begin
               if (timer_q == '0) begin
                  restart_q <= 1'b0;
                  bits_q <= '0;
                  state_q <= rfid_pkg::host_wait_found;
               end else begin
                  timer_q <= timer_q - 1'b1;
               end
            end
            rfid_pkg::host_wait_found: begin
               if (found_sync_q[1]) begin
                  state_q <= rfid_pkg::host_sample;
               end
            end
            rfid_pkg::host_sample: begin
               word_q <= {word_q[WIDTH-2:0], serial_sync_q[1]};
               bits_q <= bits_q + 1'b1;
               if (bits_q == BW'(rfid_pkg::SHIFT_EDGES)) begin
                  state_q <= rfid_pkg::host_push;
               end else begin
                  sck_q <= 1'b1;
                  timer_q <= TW'(rfid_pkg::SCK_CYCLES - 1);
                  state_q <= rfid_pkg::host_sck_high;
               end
            end
            rfid_pkg::host_sck_high: begin
               if (timer_q == '0) begin
                  sck_q <= 1'b0;
                  timer_q <= TW'(rfid_pkg::SCK_CYCLES - 1);
                  state_q <= rfid_pkg::host_sck_low;
               end else begin
                  timer_q <= timer_q - 1'b1;
               end
            end
            rfid_pkg::host_sck_low: begin
               // covers device edge detect plus our own synchroniser
               if (timer_q == '0) begin
                  state_q <= rfid_pkg::host_sample;
               end else begin
                  timer_q <= timer_q - 1'b1;
               end
            end
            rfid_pkg::host_push: begin
               if (in_ready) begin
                  restart_q <= 1'b1;
                  timer_q <= TW'(rfid_pkg::RESTART_CYCLES - 1);
                  state_q <= rfid_pkg::host_restart;
               end
            end
         endcase
      end
   end

   assign link.power_on = power_q;
   assign link.restart = restart_q;
   assign link.shift_clk = sck_q;

   // full buffer stalls the next restart, so no id is dropped
   assign in_ready = (count_q != NW'(DEPTH));
   assign push = (state_q == rfid_pkg::host_push) && in_ready;
   assign pop = id_valid_o && id_ready_i;

   always_ff @(posedge sys_clk_i) begin
      if (!rstn_i) begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
         count_q <= '0;
      end else begin
         if (push) begin
            wr_ptr_q <= (wr_ptr_q == PW'(DEPTH - 1)) ? '0 : wr_ptr_q + 1'b1;
         end
         if (pop) begin
            rd_ptr_q <= (rd_ptr_q == PW'(DEPTH - 1)) ? '0 : rd_ptr_q + 1'b1;
         end
         if (push && !pop) begin
            count_q <= count_q + 1'b1;
         end else if (pop && !push) begin
            count_q <= count_q - 1'b1;
         end
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (push) begin
         mem_q[wr_ptr_q] <= word_q;
      end
   end

   assign id_valid_o = (count_q != '0);
   assign id_data_o = mem_q[rd_ptr_q];
endmodule : rfid_host_reader
`default_nettype wire

// *** testbench/rfid_link_asserts.sv ***
`timescale 1ns/1ps
`default_nettype none
module rfid_link_asserts #(
   parameter int unsigned SAMPLE_CYCLES = rfid_pkg::SAMPLE_CYCLES
) (
   input wire logic sys_clk_i,
   input wire logic rstn_i,
   input wire logic power_on,
   input wire logic restart,
   input wire logic shift_clk,
   input wire logic found,
   input wire logic serial_id_out
);
   localparam int unsigned MIN_ACQ = (rfid_pkg::HALF_BITS - 1) * SAMPLE_CYCLES;
   int unsigned quiet_q;
   logic [5:0] edges_q;
   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (!rstn_i);
   // host may cut a pulse short only by powering the core off
   sequence s_held20(sig);
      sig[*8] ##1 sig[*8] ##1 sig[*4];
   endsequence
   // cycles since the host last held the core idle
   always_ff @(posedge sys_clk_i) begin
      if (!rstn_i || restart || !power_on) begin
         quiet_q <= 0;
      end else if (quiet_q < MIN_ACQ) begin
         quiet_q <= quiet_q + 1;
      end
   end
   always_ff @(posedge sys_clk_i) begin
      if (!rstn_i || !found) begin
         edges_q <= '0;
      end else if ($rose(shift_clk)) begin
         edges_q <= edges_q + 6'h01;
      end
   end
   a_acq_time: assert property ($rose(found) |-> quiet_q >= MIN_ACQ)
      else $error("found rose before a full acquisition");
   a_restart_clears: assert property (restart[*5] |-> !found)
      else $error("found high during restart");
   a_power_idle: assert property ((!power_on)[*5] |-> !found)
      else $error("found high while unpowered");
   a_found_sticky: assert property ($fell(found) |-> quiet_q < 6)
      else $error("found fell without restart or power off");
   a_bit_on_edge: assert property (
      found && $past(found) && $changed(serial_id_out)
      |-> $past(shift_clk, 2) && !$past(shift_clk, 7))
      else $error("serial bit moved without a shift edge");
   a_shift_found: assert property ($rose(shift_clk) |-> found)
      else $error("shift edge while found low");
   a_edge_count: assert property ($rose(shift_clk) |-> edges_q < 6'h27)
      else $error("more than 39 shift edges in one transfer");
   a_restart_width: assert property (
      $rose(restart) |-> s_held20(restart || !power_on))
      else $error("restart pulse too short");
   a_sck_width: assert property (
      $rose(shift_clk) |-> s_held20(shift_clk || !power_on))
      else $error("shift clock high phase too short");
endmodule : rfid_link_asserts
`default_nettype wire

// *** testbench/test_rfid_tag_frame_decoder.sv ***
`timescale 1ns/1ps
`default_nettype none
module test_rfid_tag_frame_decoder;
   localparam int unsigned SC = 4;
   typedef struct {
      logic [39:0] id;
      logic [39:0] word;
   } row_t;
   row_t rows [4] = '{'{40'h0000000000, 40'h0000000000},
      '{40'hffffffffff, 40'hffffffffff}, '{40'h123456789a, 40'h123456789a},
      '{40'ha5c30f96e1, 40'ha5c30f96e1}};
   logic [63:0] bad [4] = '{
      64'h8000000000000000, // header one lost
      64'h0004000000000000, // first row parity flipped
      64'h0000000000000002, // column parity flipped
      64'h0000000000000001}; // stop bit set
   logic sys_clk_i;
   logic rstn_i;
   logic tag_half_bit_i;
   logic power_en_i;
   logic id_ready_i;
   logic id_valid_o;
   logic [39:0] id_data_o;
   logic [39:0] id;
   logic [63:0] frame_q;
   // repeats each bit's first half, so no half-bit pair is opposite
   logic flat;
   int n_errors;
   int total_checks;
   rfid_link_if link ();
   rfid_link_if link2 ();
   rfid_tag_frame_decoder #(.SAMPLE_CYCLES(SC)) rfid_tag_frame_decoder_inst (
      .sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .tag_half_bit_i(tag_half_bit_i),
      .link(link));
   // second device end, faced by the bench acting as a careless host
   rfid_tag_frame_decoder #(.SAMPLE_CYCLES(SC))
      fault_rfid_tag_frame_decoder_inst (
      .sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .tag_half_bit_i(tag_half_bit_i),
      .link(link2));
   rfid_host_reader rfid_host_reader_inst (.sys_clk_i(sys_clk_i),
      .rstn_i(rstn_i), .power_en_i(power_en_i), .id_data_o(id_data_o),
      .id_valid_o(id_valid_o), .id_ready_i(id_ready_i), .link(link));
   rfid_link_asserts #(.SAMPLE_CYCLES(SC)) rfid_link_asserts_inst (
      .sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .power_on(link.power_on),
      .restart(link.restart), .shift_clk(link.shift_clk), .found(link.found),
      .serial_id_out(link.serial_id_out));
   initial begin
      sys_clk_i = 1'b0;
      forever #2.5 sys_clk_i = ~sys_clk_i;
   end
   // endless tag: each bit sent as high-low for one, low-high for zero
   initial begin
      tag_half_bit_i = 1'b0;
      forever begin
         for (int i = 63; i >= 0; i--) begin
            #1 tag_half_bit_i = frame_q[i];
            repeat (SC) @(posedge sys_clk_i);
            #1 tag_half_bit_i = frame_q[i] ^ !flat;
            repeat (SC) @(posedge sys_clk_i);
         end
      end
   end
   function automatic logic [63:0] make_frame(input logic [39:0] d);
      logic [63:0] f;
      logic [3:0] col;
      f = '0;
      col = '0;
      f[63:55] = 9'h1ff;
      for (int r = 0; r < 10; r++) begin
         f[54-5*r -: 4] = d[39-4*r -: 4];
         f[50-5*r] = ^d[39-4*r -: 4];
         col = col ^ d[39-4*r -: 4];
      end
      f[4:1] = col;
      return f;
   endfunction : make_frame
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk_i);
      #1;
   endtask : tick
   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task automatic stop_test();
      $display("checks=%0d errors=%0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : stop_test
   task automatic pulse2();
      link2.restart = 1'b1;
      tick(20);
      link2.restart = 1'b0;
      tick(1);
   endtask : pulse2
   // 48 ns link clock, free of sys_clk phase
   task automatic sck2();
      link2.shift_clk = 1'b1;
      #24;
      link2.shift_clk = 1'b0;
      #24;
   endtask : sck2
   task automatic reset_test();
      rstn_i = 1'b0;
      tick(5);
      check(link.power_on, 1'b0);
      check(link.restart, 1'b0);
      check(link.shift_clk, 1'b0);
      check(link.found, 1'b0);
      check(link.serial_id_out, 1'b0);
      check(id_valid_o, 1'b0);
      rstn_i = 1'b1;
      $display("reset test done");
   endtask : reset_test
   initial begin
      repeat (60000) @(posedge sys_clk_i);
      n_errors++;
      stop_test();
   end
   initial begin
      n_errors = 0;
      total_checks = 0;
      power_en_i = 1'b0;
      id_ready_i = 1'b0;
      flat = 1'b0;
      frame_q = make_frame(rows[0].id);
      link2.power_on = 1'b0;
      link2.restart = 1'b0;
      link2.shift_clk = 1'b0;
      reset_test();
      foreach (rows[k]) begin
         // power off and drain so no stale word survives the frame change
         power_en_i = 1'b0;
         id_ready_i = 1'b1;
         frame_q = make_frame(rows[k].id);
         tick(10);
         id_ready_i = 1'b0;
         power_en_i = 1'b1;
         for (int n = 0; n < 4000 && id_valid_o !== 1'b1; n++) tick(1);
         check(id_valid_o, 1'b1);
         check(id_data_o, rows[k].word);
         $display("row %0d done", k);
      end
      // stalled user: buffer fills, host holds, device stays found
      tick(6000);
      check(link.found, 1'b1);
      check(link.restart, 1'b0);
      power_en_i = 1'b0;
      id_ready_i = 1'b1;
      for (int k = 0; k < 2; k++) begin
         check(id_valid_o, 1'b1);
         check(id_data_o, rows[3].word);
         tick(1);
      end
      check(id_valid_o, 1'b0);
      $display("buffer test done");
      id = rows[3].id;
      pulse2();
      tick(1500);
      check(link2.found, 1'b0);
      link2.power_on = 1'b1;
      pulse2();
      repeat (5) sck2();
      for (int n = 0; n < 4000 && link2.found !== 1'b1; n++) tick(1);
      check(link2.found, 1'b1);
      check(link2.serial_id_out, id[39]);
      for (int b = 38; b >= 0; b--) begin
         sck2();
         check(link2.serial_id_out, id[b]);
      end
      repeat (3) sck2();
      check(link2.serial_id_out, id[0]);
      tick(1000);
      check(link2.found, 1'b1);
      pulse2();
      check(link2.found, 1'b0);
      $display("transfer test done");
      foreach (bad[m]) begin
         frame_q = make_frame(id) ^ bad[m];
         pulse2();
         tick(1500);
         check(link2.found, 1'b0);
      end
      // a good frame without opposite halves must never be accepted
      flat = 1'b1;
      frame_q = make_frame(id);
      pulse2();
      tick(1500);
      check(link2.found, 1'b0);
      flat = 1'b0;
      $display("bad frame test done");
      power_en_i = 1'b1;
      tick(50);
      reset_test();
      stop_test();
   end
endmodule : test_rfid_tag_frame_decoder
`default_nettype wire
